//--- hw/mmtr_pkg.sv
// shared constants, encodings and types of the multi-mode timing relay
package mmtr_pkg;
  localparam int SP_W = 14;
  localparam int EL_W = 17;
  localparam int SCAN_W = 16;
  localparam int QV_W = 32;
  localparam int RND_W = 16;
  localparam int VAR_W = 32;
  localparam int RET_BYTES = 4;
  localparam int RET_W = RET_BYTES * 8;

  // time range selection
  localparam logic [1:0] RANGE_S = 2'h0;
  localparam logic [1:0] RANGE_MS = 2'h1;
  localparam logic [1:0] RANGE_HM = 2'h2;

  // largest setpoint: 99.99 in hundredths, 99:59 in base units
  localparam logic [SP_W-1:0] SP_MAX_S = 14'h270F;
  localparam logic [SP_W-1:0] SP_MAX_MIN = 14'h176F;

  // largest elapsed value shown
  localparam logic [EL_W-1:0] EL_CAP = 17'h18696;
  localparam logic [EL_W-1:0] EL_ZERO = 17'h00000;

  // operating modes
  localparam logic [1:0] MODE_OFF_DLY = 2'h0;
  localparam logic [1:0] MODE_ON_OFF = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] MODE_FLASH = 2'h3;

  // random source, seeds are arbitrary
  localparam logic [RND_W-1:0] LFSR_SEED_A = 16'hACE1;
  localparam logic [RND_W-1:0] LFSR_SEED_B = 16'h5A3C;
  localparam logic [RND_W-1:0] LFSR_TAPS = 16'hB400;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ON_WAIT = 7'h02,
    ST_HOLD = 7'h04,
    ST_RUNDOWN = 7'h08,
    ST_PULSE = 7'h10,
    ST_FLASH_ON = 7'h20,
    ST_FLASH_OFF = 7'h40
  } mmtr_state_t;

  function automatic logic [SP_W-1:0] sp_max_of(input logic [1:0] range);
    sp_max_of = (range == RANGE_S) ? SP_MAX_S : SP_MAX_MIN;
  endfunction : sp_max_of
endpackage : mmtr_pkg

//--- hw/mmtr_sp_clamp.sv
// setpoint source select with saturation to the time range maximum
`timescale 1ns/1ps
module mmtr_sp_clamp (
  // setpoint sources
  input wire logic [mmtr_pkg::SP_W-1:0] const_sp,
  input wire logic [mmtr_pkg::VAR_W-1:0] var_sp,
  input wire logic use_var,
  // configuration
  input wire logic [1:0] time_range,
  // effective setpoint
  output logic [mmtr_pkg::SP_W-1:0] sp_out
);
  localparam int PAD_W = mmtr_pkg::VAR_W - mmtr_pkg::SP_W;

  wire [mmtr_pkg::SP_W-1:0] max_w;
  wire [mmtr_pkg::VAR_W-1:0] raw_w;
  wire [mmtr_pkg::VAR_W-1:0] max32_w;
  wire over_w;

  assign max_w = mmtr_pkg::sp_max_of(time_range);
  assign max32_w = {{PAD_W{1'b0}}, max_w};
  assign raw_w = use_var ? var_sp : {{PAD_W{1'b0}}, const_sp};
  // saturate instead of wrapping a large counter value
  assign over_w = raw_w > max32_w;
  assign sp_out = over_w ? max_w : raw_w[mmtr_pkg::SP_W-1:0];
endmodule : mmtr_sp_clamp

//--- hw/mmtr_rand_scale.sv
// free-running lfsr scaled into the range zero to a setpoint
`timescale 1ns/1ps
module mmtr_rand_scale #(
  parameter logic [mmtr_pkg::RND_W-1:0] SEED = mmtr_pkg::LFSR_SEED_A
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // scaling
  input wire logic [mmtr_pkg::SP_W-1:0] range_in,
  output logic [mmtr_pkg::SP_W-1:0] rand_out
);
  localparam int PROD_W = mmtr_pkg::SP_W + 1 + mmtr_pkg::RND_W;

  logic [mmtr_pkg::RND_W-1:0] lfsr_r;
  wire [mmtr_pkg::RND_W-1:0] lfsr_nxt;
  wire [mmtr_pkg::SP_W:0] span_w;
  wire [PROD_W-1:0] prod_w;

  assign lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ mmtr_pkg::LFSR_TAPS) : (lfsr_r >> 1);
  // multiply-and-shift avoids a divider and never exceeds range_in
  assign span_w = {1'b0, range_in} + {{mmtr_pkg::SP_W{1'b0}}, 1'b1};
  assign prod_w = PROD_W'(span_w) * PROD_W'(lfsr_r);
  assign rand_out = prod_w[mmtr_pkg::RND_W +: mmtr_pkg::SP_W];

  always_ff @(posedge clk) begin
    if (reset) begin
      lfsr_r <= SEED;
    end else begin
      lfsr_r <= lfsr_nxt;
    end
  end

  AST_RAND_IN_RANGE: assert property (@(posedge clk) disable iff (reset)
    rand_out <= range_in)
    else $error("random delay above setpoint");
endmodule : mmtr_rand_scale

//--- hw/mmtr_top.sv
// multi-mode timing relay: off-delay, on/off-delay, single pulse, flashing
`timescale 1ns/1ps
module mmtr_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // coils
  input wire logic trigger_coil,
  input wire logic stop_coil,
  input wire logic clear_coil,
  // program scan
  input wire logic scan_tick,
  input wire logic [mmtr_pkg::SCAN_W-1:0] scan_time,
  input wire logic run_mode,
  // configuration
  input wire logic [1:0] op_mode,
  input wire logic retrigger_en,
  input wire logic random_en,
  input wire logic retentive_en,
  input wire logic [1:0] time_range,
  // setpoints
  input wire logic [mmtr_pkg::SP_W-1:0] first_time_setpoint,
  input wire logic [mmtr_pkg::SP_W-1:0] second_time_setpoint,
  input wire logic [mmtr_pkg::VAR_W-1:0] first_var_setpoint,
  input wire logic [mmtr_pkg::VAR_W-1:0] second_var_setpoint,
  input wire logic first_sp_is_var,
  input wire logic second_sp_is_var,
  // results
  output logic switching_contact,
  output logic [mmtr_pkg::QV_W-1:0] elapsed_time_value,
  output logic [mmtr_pkg::RET_W-1:0] retained_value
);
  localparam int EL_PAD = mmtr_pkg::QV_W - mmtr_pkg::EL_W;
  localparam int RET_PAD = mmtr_pkg::RET_W - mmtr_pkg::EL_W;
  localparam int TGT_PAD = mmtr_pkg::EL_W - mmtr_pkg::SP_W;
  localparam int SCN_PAD = mmtr_pkg::EL_W - mmtr_pkg::SCAN_W;

  ////////////////////////////////////////////////////////////////////////////
  // state
  mmtr_pkg::mmtr_state_t state_r;
  mmtr_pkg::mmtr_state_t state_nxt;
  logic [mmtr_pkg::EL_W-1:0] elapsed_r;
  logic [mmtr_pkg::EL_W-1:0] elapsed_nxt;
  logic [mmtr_pkg::EL_W-1:0] target_r;
  logic [mmtr_pkg::EL_W-1:0] target_nxt;
  logic contact_r;
  logic contact_nxt;
  logic trig_prev_r;
  logic run_r;
  logic [mmtr_pkg::RET_W-1:0] ret_store_r;

  ////////////////////////////////////////////////////////////////////////////
  // setpoint paths: clamp, then optional random scaling
  wire [mmtr_pkg::SP_W-1:0] sp_const_a [0:1];
  wire [mmtr_pkg::VAR_W-1:0] sp_var_a [0:1];
  wire sp_use_var_a [0:1];
  wire [mmtr_pkg::SP_W-1:0] sp_eff_a [0:1];
  wire [mmtr_pkg::SP_W-1:0] sp_rnd_a [0:1];
  wire [mmtr_pkg::EL_W-1:0] phase_tgt_a [0:1];

  assign sp_const_a[0] = first_time_setpoint;
  assign sp_const_a[1] = second_time_setpoint;
  assign sp_var_a[0] = first_var_setpoint;
  assign sp_var_a[1] = second_var_setpoint;
  assign sp_use_var_a[0] = first_sp_is_var;
  assign sp_use_var_a[1] = second_sp_is_var;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sp
      mmtr_sp_clamp u_clamp (
        .const_sp(sp_const_a[g]),
        .var_sp(sp_var_a[g]),
        .use_var(sp_use_var_a[g]),
        .time_range(time_range),
        .sp_out(sp_eff_a[g])
      );
      mmtr_rand_scale #(
        .SEED((g == 0) ? mmtr_pkg::LFSR_SEED_A : mmtr_pkg::LFSR_SEED_B)
      ) u_rand (
        .clk(clk),
        .reset(reset),
        .range_in(sp_eff_a[g]),
        .rand_out(sp_rnd_a[g])
      );
      // the draw is latched once per phase, so a frozen phase keeps its target
      assign phase_tgt_a[g] = {{TGT_PAD{1'b0}}, (random_en ? sp_rnd_a[g] : sp_eff_a[g])};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // scan timing decode
  wire restart_w;
  wire tick_w;
  wire timing_w;
  wire adv_w;
  wire done_w;
  wire trig_rise_w;
  wire [mmtr_pkg::EL_W:0] sum_w;
  wire [mmtr_pkg::EL_W-1:0] adv_val_w;
  wire [mmtr_pkg::EL_W-1:0] hold_tgt_w;

  assign restart_w = run_mode && !run_r;
  assign tick_w = scan_tick && run_mode && run_r;
  assign timing_w = (state_r == mmtr_pkg::ST_ON_WAIT) || (state_r == mmtr_pkg::ST_RUNDOWN)
                 || (state_r == mmtr_pkg::ST_PULSE) || (state_r == mmtr_pkg::ST_FLASH_ON)
                 || (state_r == mmtr_pkg::ST_FLASH_OFF);
  // stop coil only withholds the advance; all other transitions still act
  assign adv_w = tick_w && timing_w && !stop_coil;
  assign sum_w = {1'b0, elapsed_r} + {{(SCN_PAD + 1){1'b0}}, scan_time};
  assign done_w = sum_w >= {1'b0, target_r};
  assign adv_val_w = done_w ? target_r : sum_w[mmtr_pkg::EL_W-1:0];
  assign trig_rise_w = trigger_coil && !trig_prev_r;
  // a partial off-delay keeps its own target so the two parts add up
  assign hold_tgt_w = (op_mode == mmtr_pkg::MODE_OFF_DLY)
                    ? ((elapsed_r != mmtr_pkg::EL_ZERO) ? target_r : phase_tgt_a[0])
                    : phase_tgt_a[1];

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  always_comb begin
    state_nxt = state_r;
    elapsed_nxt = adv_w ? adv_val_w : elapsed_r;
    target_nxt = target_r;
    contact_nxt = contact_r;
    if (clear_coil) begin
      state_nxt = mmtr_pkg::ST_IDLE;
      elapsed_nxt = mmtr_pkg::EL_ZERO;
      contact_nxt = 1'b0;
    end else if (restart_w) begin
      if (retentive_en) begin
        elapsed_nxt = ret_store_r[mmtr_pkg::EL_W-1:0];
      end else begin
        state_nxt = mmtr_pkg::ST_IDLE;
        elapsed_nxt = mmtr_pkg::EL_ZERO;
        contact_nxt = 1'b0;
      end
    end else if (tick_w) begin
      case (state_r)
        mmtr_pkg::ST_IDLE: begin
          case (op_mode)
            mmtr_pkg::MODE_OFF_DLY: begin
              if (trigger_coil) begin
                state_nxt = mmtr_pkg::ST_HOLD;
                contact_nxt = 1'b1;
                elapsed_nxt = mmtr_pkg::EL_ZERO;
              end
            end
            mmtr_pkg::MODE_ON_OFF: begin
              if (trigger_coil) begin
                state_nxt = mmtr_pkg::ST_ON_WAIT;
                elapsed_nxt = mmtr_pkg::EL_ZERO;
                target_nxt = phase_tgt_a[0];
              end
            end
            mmtr_pkg::MODE_PULSE: begin
              if (trig_rise_w) begin
                state_nxt = mmtr_pkg::ST_PULSE;
                contact_nxt = 1'b1;
                elapsed_nxt = mmtr_pkg::EL_ZERO;
                target_nxt = phase_tgt_a[0];
              end
            end
            default: begin
              if (trigger_coil) begin
                state_nxt = mmtr_pkg::ST_FLASH_ON;
                contact_nxt = 1'b1;
                elapsed_nxt = mmtr_pkg::EL_ZERO;
                target_nxt = phase_tgt_a[0];
              end
            end
          endcase
        end
        mmtr_pkg::ST_ON_WAIT: begin
          if (!trigger_coil) begin
            state_nxt = mmtr_pkg::ST_IDLE;
          end else if (adv_w && done_w) begin
            state_nxt = mmtr_pkg::ST_HOLD;
            contact_nxt = 1'b1;
            elapsed_nxt = mmtr_pkg::EL_ZERO;
          end
        end
        mmtr_pkg::ST_HOLD: begin
          if (!trigger_coil) begin
            state_nxt = mmtr_pkg::ST_RUNDOWN;
            target_nxt = hold_tgt_w;
          end
        end
        mmtr_pkg::ST_RUNDOWN: begin
          if (trigger_coil) begin
            state_nxt = mmtr_pkg::ST_HOLD;
            elapsed_nxt = (retrigger_en || op_mode == mmtr_pkg::MODE_ON_OFF)
                        ? mmtr_pkg::EL_ZERO : elapsed_r;
          end else if (adv_w && done_w) begin
            state_nxt = mmtr_pkg::ST_IDLE;
            contact_nxt = 1'b0;
          end
        end
        mmtr_pkg::ST_PULSE: begin
          // trigger level is ignored here, so a short trigger is lengthened
          if (adv_w && done_w) begin
            state_nxt = mmtr_pkg::ST_IDLE;
            contact_nxt = 1'b0;
          end
        end
        mmtr_pkg::ST_FLASH_ON: begin
          if (!trigger_coil) begin
            state_nxt = mmtr_pkg::ST_IDLE;
            contact_nxt = 1'b0;
            elapsed_nxt = mmtr_pkg::EL_ZERO;
          end else if (adv_w && done_w) begin
            state_nxt = mmtr_pkg::ST_FLASH_OFF;
            contact_nxt = 1'b0;
            elapsed_nxt = mmtr_pkg::EL_ZERO;
            target_nxt = phase_tgt_a[1];
          end
        end
        mmtr_pkg::ST_FLASH_OFF: begin
          if (!trigger_coil) begin
            state_nxt = mmtr_pkg::ST_IDLE;
            contact_nxt = 1'b0;
            elapsed_nxt = mmtr_pkg::EL_ZERO;
          end else if (adv_w && done_w) begin
            state_nxt = mmtr_pkg::ST_FLASH_ON;
            contact_nxt = 1'b1;
            elapsed_nxt = mmtr_pkg::EL_ZERO;
            target_nxt = phase_tgt_a[0];
          end
        end
        default: begin
          state_nxt = mmtr_pkg::ST_IDLE;
          contact_nxt = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= mmtr_pkg::ST_IDLE;
      target_r <= mmtr_pkg::EL_ZERO;
      contact_r <= 1'b0;
      trig_prev_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      target_r <= target_nxt;
      contact_r <= contact_nxt;
      run_r <= run_mode;
      // tracking the trigger during clear hides a held trigger as an edge
      if (tick_w || clear_coil) begin
        trig_prev_r <= trigger_coil;
      end
    end
  end

  // retained image models nonvolatile storage: reset spares it when retentive
  always_ff @(posedge clk) begin
    if (reset) begin
      elapsed_r <= retentive_en ? ret_store_r[mmtr_pkg::EL_W-1:0] : mmtr_pkg::EL_ZERO;
      if (!retentive_en) begin
        ret_store_r <= {mmtr_pkg::RET_W{1'b0}};
      end
    end else begin
      elapsed_r <= elapsed_nxt;
      if (retentive_en && run_mode) begin
        ret_store_r <= {{RET_PAD{1'b0}}, elapsed_nxt};
      end
    end
  end

  assign switching_contact = contact_r;
  assign elapsed_time_value = {{EL_PAD{1'b0}}, elapsed_r};
  assign retained_value = ret_store_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_CLEAR_ZEROES: assert property (@(posedge clk) disable iff (reset)
    clear_coil |=> (!contact_r && elapsed_r == mmtr_pkg::EL_ZERO && state_r == mmtr_pkg::ST_IDLE))
    else $error("clear coil did not zero the relay");

  AST_STOP_FREEZES: assert property (@(posedge clk) disable iff (reset)
    (state_r == mmtr_pkg::ST_RUNDOWN && stop_coil && !trigger_coil && !clear_coil
     && run_mode && run_r) |=> $stable(elapsed_r))
    else $error("elapsed time moved under stop coil");

  AST_PICKUP_HALT: assert property (@(posedge clk) disable iff (reset)
    (state_r == mmtr_pkg::ST_ON_WAIT && stop_coil && trigger_coil && !clear_coil
     && run_mode && run_r) |=> (state_r == mmtr_pkg::ST_ON_WAIT && $stable(elapsed_r)))
    else $error("pick-up delay advanced under stop coil");

  AST_RUNDOWN_HOLDS: assert property (@(posedge clk) disable iff (reset)
    (state_r == mmtr_pkg::ST_RUNDOWN || state_r == mmtr_pkg::ST_HOLD) |-> contact_r)
    else $error("contact dropped before off-delay completed");

  AST_OFFDLY_PICKUP: assert property (@(posedge clk) disable iff (reset)
    (tick_w && op_mode == mmtr_pkg::MODE_OFF_DLY && trigger_coil && !clear_coil)
    |=> contact_r)
    else $error("off-delay contact not on with trigger");

  AST_ONOFF_EARLY: assert property (@(posedge clk) disable iff (reset)
    state_r == mmtr_pkg::ST_ON_WAIT |-> !contact_r)
    else $error("contact on before pick-up elapsed");

  AST_RETRIG_ZERO: assert property (@(posedge clk) disable iff (reset)
    (tick_w && retrigger_en && state_r == mmtr_pkg::ST_RUNDOWN && trigger_coil && !clear_coil)
    |=> (elapsed_r == mmtr_pkg::EL_ZERO && state_r == mmtr_pkg::ST_HOLD))
    else $error("retrigger did not restart the delay");

  AST_PULSE_STRETCH: assert property (@(posedge clk) disable iff (reset)
    (tick_w && state_r == mmtr_pkg::ST_PULSE && !trigger_coil && !clear_coil && !done_w)
    |=> (state_r == mmtr_pkg::ST_PULSE && contact_r))
    else $error("short trigger cut the pulse");

  AST_NO_PULSE_HELD: assert property (@(posedge clk) disable iff (reset)
    ($fell(clear_coil) && trigger_coil && $past(trigger_coil)
     && op_mode == mmtr_pkg::MODE_PULSE) |=> !contact_r)
    else $error("pulse fired without fresh trigger edge");

  AST_FLASH_TOGGLE: assert property (@(posedge clk) disable iff (reset)
    (tick_w && state_r == mmtr_pkg::ST_FLASH_ON && trigger_coil && !clear_coil && adv_w && done_w)
    |=> (state_r == mmtr_pkg::ST_FLASH_OFF && !contact_r))
    else $error("flash did not enter pause");

  AST_SP_SATURATE: assert property (@(posedge clk) disable iff (reset)
    sp_eff_a[0] <= mmtr_pkg::sp_max_of(time_range))
    else $error("setpoint above range maximum");

  AST_QV_CAP: assert property (@(posedge clk) disable iff (reset)
    elapsed_r <= mmtr_pkg::EL_CAP)
    else $error("elapsed time above cap");

  AST_SCAN_ONLY: assert property (@(posedge clk) disable iff (reset)
    (!tick_w && !clear_coil && !restart_w) |=> ($stable(elapsed_r) && $stable(state_r)))
    else $error("timing moved between scans");

  AST_RET_RESUME: assert property (@(posedge clk) disable iff (reset)
    (restart_w && retentive_en && !clear_coil) |=> elapsed_r == $past(ret_store_r[mmtr_pkg::EL_W-1:0]))
    else $error("retentive value not resumed");
endmodule : mmtr_top

//--- verif/mmtr_prog_model.sv
// control program model: issues program scans and their scan time
`timescale 1ns/1ps
module mmtr_prog_model (
  // clock
  input wire logic clk,
  // scan outputs
  output logic scan_tick,
  output logic [mmtr_pkg::SCAN_W-1:0] scan_time
);
  initial begin
    scan_tick = 1'h0;
    scan_time = 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // back-to-back scans, all launched off the falling edge, away from the sampling edge
  task automatic scan(input int n, input logic [mmtr_pkg::SCAN_W-1:0] st);
    scan_time = st;
    repeat (n) begin
      @(negedge clk);
      scan_tick = 1'h1;
    end
    @(negedge clk);
    scan_tick = 1'h0;
  endtask : scan
endmodule : mmtr_prog_model

//--- verif/mmtr_top_tb.sv
// self-checking bench of the multi-mode timing relay
`timescale 1ns/1ps
module mmtr_top_tb;
  logic clk, reset, trigger_coil, stop_coil, clear_coil, run_mode;
  logic retrigger_en, random_en, retentive_en, first_sp_is_var;
  logic [1:0] op_mode, time_range;
  logic [mmtr_pkg::SP_W-1:0] sp1, sp2;
  logic [mmtr_pkg::VAR_W-1:0] var1;
  logic [mmtr_pkg::SCAN_W-1:0] st;
  logic scan_tick, contact;
  logic [mmtr_pkg::SCAN_W-1:0] scan_time;
  logic [31:0] elapsed, retained;
  int n_mismatch = 0;
  int tests_run = 0;

  mmtr_prog_model pm (.clk(clk), .scan_tick(scan_tick), .scan_time(scan_time));

  mmtr_top dut (
    .clk(clk), .reset(reset), .trigger_coil(trigger_coil), .stop_coil(stop_coil),
    .clear_coil(clear_coil), .scan_tick(scan_tick), .scan_time(scan_time),
    .run_mode(run_mode), .op_mode(op_mode), .retrigger_en(retrigger_en),
    .random_en(random_en), .retentive_en(retentive_en), .time_range(time_range),
    .first_time_setpoint(sp1), .second_time_setpoint(sp2),
    .first_var_setpoint(var1), .second_var_setpoint(32'h00000000),
    .first_sp_is_var(first_sp_is_var), .second_sp_is_var(1'h0),
    .switching_contact(contact), .elapsed_time_value(elapsed), .retained_value(retained)
  );

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_c(input logic exp);
    tests_run++;
    if (contact !== exp) begin
      n_mismatch++;
      $display("Error at %0t: contact %h expected %h", $time, contact, exp);
    end
  endtask : chk_c

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic sc(input int n, input logic exp);
    pm.scan(n, st);
    chk_c(exp);
  endtask : sc

  // clear pulse brings every mode back to idle between tests
  task automatic setup(input logic [1:0] m, input logic rt, input logic [13:0] a,
                       input logic [13:0] b);
    op_mode = m;
    retrigger_en = rt;
    sp1 = a;
    sp2 = b;
    st = 16'h0001;
    trigger_coil = 1'h0;
    stop_coil = 1'h0;
    clear_coil = 1'h1;
    cyc(1);
    clear_coil = 1'h0;
  endtask : setup

  task automatic tdone(input string s);
    $display("test %s finished", s);
  endtask : tdone

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #10000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    reset = 1'h1;
    {trigger_coil, stop_coil, clear_coil, run_mode, retrigger_en} = 5'h00;
    {random_en, retentive_en, first_sp_is_var} = 3'h0;
    op_mode = mmtr_pkg::MODE_OFF_DLY;
    time_range = mmtr_pkg::RANGE_MS;
    sp1 = 14'h0000;
    sp2 = 14'h0000;
    var1 = 32'h00007A65;
    st = 16'h0001;
    cyc(4);
    reset = 1'h0;
    run_mode = 1'h1;
    cyc(2);
    setup(mmtr_pkg::MODE_OFF_DLY, 1'h0, 14'h0003, 14'h0000);
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    trigger_coil = 1'h0;
    sc(3, 1'h1);
    chk_v(elapsed, 32'h00000002);
    sc(1, 1'h0);
    chk_v(elapsed, 32'h00000003);
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    trigger_coil = 1'h0;
    sc(2, 1'h1);
    stop_coil = 1'h1;
    sc(4, 1'h1);
    chk_v(elapsed, 32'h00000001);
    stop_coil = 1'h0;
    sc(1, 1'h1);
    sc(1, 1'h0);
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    trigger_coil = 1'h0;
    sc(2, 1'h1);
    clear_coil = 1'h1;
    cyc(1);
    chk_c(1'h0);
    chk_v(elapsed, 32'h00000000);
    clear_coil = 1'h0;
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    tdone("off_delay");
    for (int r = 0; r < 2; r++) begin
      setup(mmtr_pkg::MODE_OFF_DLY, r[0], 14'h0004, 14'h0000);
      trigger_coil = 1'h1;
      sc(1, 1'h1);
      trigger_coil = 1'h0;
      sc(3, 1'h1);
      trigger_coil = 1'h1;
      sc(1, 1'h1);
      trigger_coil = 1'h0;
      sc(1, 1'h1);
      chk_v(elapsed, r ? 32'h00000000 : 32'h00000002);
      sc(r ? 3 : 1, 1'h1);
      sc(1, 1'h0);
    end
    tdone("double_dropout");
    setup(mmtr_pkg::MODE_ON_OFF, 1'h0, 14'h0002, 14'h0003);
    trigger_coil = 1'h1;
    sc(1, 1'h0);
    trigger_coil = 1'h0;
    sc(3, 1'h0);
    trigger_coil = 1'h1;
    sc(1, 1'h0);
    stop_coil = 1'h1;
    sc(3, 1'h0);
    stop_coil = 1'h0;
    sc(1, 1'h0);
    sc(1, 1'h1);
    trigger_coil = 1'h0;
    sc(3, 1'h1);
    sc(1, 1'h0);
    tdone("on_off");
    setup(mmtr_pkg::MODE_PULSE, 1'h0, 14'h0003, 14'h0000);
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    trigger_coil = 1'h0;
    sc(2, 1'h1);
    sc(1, 1'h0);
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    trigger_coil = 1'h0;
    stop_coil = 1'h1;
    sc(4, 1'h1);
    stop_coil = 1'h0;
    sc(2, 1'h1);
    sc(1, 1'h0);
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    clear_coil = 1'h1;
    cyc(1);
    clear_coil = 1'h0;
    sc(4, 1'h0);
    tdone("pulse");
    setup(mmtr_pkg::MODE_FLASH, 1'h0, 14'h0002, 14'h0001);
    trigger_coil = 1'h1;
    sc(2, 1'h1);
    sc(1, 1'h0);
    sc(1, 1'h1);
    stop_coil = 1'h1;
    sc(3, 1'h1);
    stop_coil = 1'h0;
    sc(1, 1'h1);
    sc(1, 1'h0);
    clear_coil = 1'h1;
    cyc(1);
    chk_c(1'h0);
    chk_v(elapsed, 32'h00000000);
    clear_coil = 1'h0;
    tdone("flash");
    for (int k = 0; k < 2; k++) begin
      time_range = k ? mmtr_pkg::RANGE_HM : mmtr_pkg::RANGE_S;
      first_sp_is_var = k[0];
      setup(mmtr_pkg::MODE_OFF_DLY, 1'h0, 14'h3FFF, 14'h0000);
      st = k ? 16'h03E8 : 16'h1388;
      trigger_coil = 1'h1;
      sc(1, 1'h1);
      trigger_coil = 1'h0;
      sc(k ? 6 : 2, 1'h1);
      sc(1, 1'h0);
      chk_v(elapsed, k ? 32'h0000176F : 32'h0000270F);
    end
    time_range = mmtr_pkg::RANGE_MS;
    first_sp_is_var = 1'h0;
    tdone("clamp");
    random_en = 1'h1;
    setup(mmtr_pkg::MODE_OFF_DLY, 1'h0, 14'h0003, 14'h0000);
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    trigger_coil = 1'h0;
    sc(4, 1'h0);
    random_en = 1'h0;
    tdone("random");
    retentive_en = 1'h1;
    setup(mmtr_pkg::MODE_OFF_DLY, 1'h0, 14'h0005, 14'h0000);
    trigger_coil = 1'h1;
    sc(1, 1'h1);
    trigger_coil = 1'h0;
    sc(3, 1'h1);
    chk_v(retained, 32'h00000002);
    run_mode = 1'h0;
    cyc(3);
    chk_v(retained, 32'h00000002);
    run_mode = 1'h1;
    cyc(2);
    chk_v(elapsed, 32'h00000002);
    sc(2, 1'h1);
    chk_v(elapsed, 32'h00000004);
    sc(1, 1'h0);
    // supply loss after the run-down has timed out: the retained count must come back
    reset = 1'h1;
    cyc(2);
    reset = 1'h0;
    cyc(2);
    chk_v(elapsed, 32'h00000005);
    chk_v(retained, 32'h00000005);
    retentive_en = 1'h0;
    tdone("retentive");
    end_of_test();
  end
endmodule : mmtr_top_tb
